/* design/efpi_map.svh */
/*
 * Register offsets, field positions, reset values and counts of the
 * external and pin-change interrupt block.
 * Assumes it is included by its bare name, before first use.
 */
`ifndef EFPI_MAP_SVH
`define EFPI_MAP_SVH

// =====================================================================
// Bus and register widths
`define EFPI_ADDR_W 8
`define EFPI_DATA_W 8
`define EFPI_RST_BYTE 8'h00

// =====================================================================
// Register offsets
`define EFPI_OFS_EXT_ENABLE 8'h3d
`define EFPI_OFS_GROUP_ENABLE 8'h68
`define EFPI_OFS_MASK_LOW 8'h6b
`define EFPI_OFS_MASK_MID 8'h6c
`define EFPI_OFS_MASK_HIGH 8'h6d
`define EFPI_OFS_SENSE 8'h69
`define EFPI_OFS_EXT_FLAGS 8'h3c
`define EFPI_OFS_GROUP_FLAGS 8'h3b

// =====================================================================
// Field layout
`define EFPI_EXT_N 2
`define EFPI_GROUP_N 3
`define EFPI_SENSE_W 2
`define EFPI_SENSE_BITS 4
`define EFPI_MID_MASK 8'h7f
`define EFPI_CHANGE_N 24
`define EFPI_SYNC_N 26

// =====================================================================
// Cycles after reset before the pin history is trusted
`define EFPI_ARM_CYCLES 2'h3

`endif

/* design/efpi_pkg.sv */
/*
 * Types shared by the interrupt block: sense modes, bus port bundle
 * and per-source request bundle.
 * Assumes efpi_map.svh is on the include path.
 */
`include "efpi_map.svh"

package efpi_pkg;

   // ==================================================================
   // Sense modes, in field order 00 low, 01 change, 10 fall, 11 rise
   typedef enum logic [`EFPI_SENSE_W-1:0] {
      efpi_sense_low,
      efpi_sense_change,
      efpi_sense_fall,
      efpi_sense_rise
   } efpi_sense_e;

   // ==================================================================
   // Register port from the core
   typedef struct packed {
      logic [`EFPI_ADDR_W-1:0] addr;
      logic [`EFPI_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } efpi_bus_s;

   // One bit per interrupt source
   typedef struct packed {
      logic [`EFPI_GROUP_N-1:0] group;
      logic [`EFPI_EXT_N-1:0] ext;
   } efpi_irq_s;

endpackage

/* design/efpi_sync.sv */
/*
 * Two-stage synchroniser for a bundle of pin levels.
 * Assumes each bit is an independent slow level from outside the
 * clock domain; no bit relation is kept across the bundle.
 */
`timescale 1ns/100ps

module efpi_sync #(
   parameter int W = 1
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);

   logic [W-1:0] meta_q;

   // =================================================================
   // First stage is read only by the second
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         meta_q <= '0;
         o_sync <= '0;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end

endmodule

/* design/efpi_top.sv */
/*
 * External and pin-change interrupt block: two dedicated interrupt
 * pins with selectable sensing, 23 pin-change inputs in three groups,
 * their control, mask and flag registers, and request outputs.
 * Assumes a core that supplies the global enable bit, pulses an
 * acknowledge when a routine is entered, and talks over a one-cycle
 * strobe register port with read data one cycle later.
 *
// How it works
// - Second pin sense field: 00 low, 01 change, 10 fall, 11 rise.
// - First pin sense field uses the same four-way encoding.
// - Pins are synchronised, then edges caught if over one clock.
// - Pin request needs its enable bit and the global enable.
// - Pins are watched whatever their port direction is.
// - Edge or change sets the pin flag; request if both enabled.
// - Pin flag clears on routine entry or a written one.
// - Pin flag is held clear while that pin senses low level.
// - Group request needs its group enable and the global enable.
// - Any change on an enabled pin of a group raises that group.
// - A pin counts only with its mask bit and group enable set.
// - Group flag set by change; cleared by entry or written one.
// - Group request needs flag, group enable and global enable.
// - Unused control, enable and flag bits read zero.
// - Middle mask keeps bits 6 to 0; bit 7 reads zero.
// - Pin-change activity signals wake without an edge mode.
// - Edges need the clock; low level is flagged as wake too.
// - Low level with enable requests for as long as pin is low.
 */
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`include "efpi_map.svh"
module efpi_top
   import efpi_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input efpi_bus_s i_bus,
   output logic [`EFPI_DATA_W-1:0] o_rdata,
   input wire logic i_global_en,
   input efpi_irq_s i_ack,
   input wire logic [`EFPI_EXT_N-1:0] i_ext_pins,
   input wire logic [`EFPI_CHANGE_N-1:0] i_change_pins,
   output efpi_irq_s o_irq_req,
   output efpi_irq_s o_flags,
   output logic o_wake
);

   // =================================================================
   // Helpers

   // Edge and change classification for the two dedicated pins
   function automatic logic edge_hit(
      input logic [`EFPI_SENSE_W-1:0] sense,
      input logic cur,
      input logic prev
   );
      logic hit;
      hit = 1'b0;
      case (efpi_sense_e'(sense))
         efpi_sense_change: hit = cur ^ prev;
         efpi_sense_fall: hit = prev & ~cur;
         efpi_sense_rise: hit = cur & ~prev;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Any masked pin of a group that toggled
   function automatic logic group_hit(
      input logic [`EFPI_DATA_W-1:0] mask,
      input logic [`EFPI_DATA_W-1:0] cur,
      input logic [`EFPI_DATA_W-1:0] prev
   );
      return |(mask & (cur ^ prev));
   endfunction

   // Low-level mode test on a sense field
   function automatic logic is_level(
      input logic [`EFPI_SENSE_W-1:0] sense
   );
      return efpi_sense_e'(sense) == efpi_sense_low;
   endfunction

   // =================================================================
   // Registers

   logic [`EFPI_SENSE_BITS-1:0] sense_q;
   logic [`EFPI_EXT_N-1:0] ext_en_q;
   logic [`EFPI_GROUP_N-1:0] grp_en_q;
   logic [`EFPI_DATA_W-1:0] mask_low_q;
   logic [`EFPI_DATA_W-1:0] mask_mid_q;
   logic [`EFPI_DATA_W-1:0] mask_high_q;
   logic [`EFPI_EXT_N-1:0] ext_flag_q;
   logic [`EFPI_EXT_N-1:0] ext_flag_d;
   logic [`EFPI_GROUP_N-1:0] grp_flag_q;
   logic [`EFPI_GROUP_N-1:0] grp_flag_d;
   logic [`EFPI_DATA_W-1:0] rdata_q;
   logic [`EFPI_DATA_W-1:0] rdata_d;
   logic [1:0] arm_cnt_q;
   logic armed;

   // Pin history
   logic [`EFPI_SYNC_N-1:0] pins_sync;
   logic [`EFPI_SYNC_N-1:0] prev_q;
   logic [`EFPI_EXT_N-1:0] ext_cur;
   logic [`EFPI_EXT_N-1:0] ext_prev;
   logic [`EFPI_CHANGE_N-1:0] chg_cur;
   logic [`EFPI_CHANGE_N-1:0] chg_prev;

   // Decoded events
   logic [`EFPI_EXT_N-1:0] ext_hit;
   logic [`EFPI_EXT_N-1:0] ext_level_mode;
   logic [`EFPI_EXT_N-1:0] ext_level_low;
   logic [`EFPI_GROUP_N-1:0] grp_hit;
   logic [`EFPI_DATA_W-1:0] grp_mask [`EFPI_GROUP_N];
   logic [`EFPI_DATA_W-1:0] grp_cur [`EFPI_GROUP_N];
   logic [`EFPI_DATA_W-1:0] grp_prev [`EFPI_GROUP_N];

   // Bus decode
   logic wr_ext_en;
   logic wr_grp_en;
   logic wr_mask_low;
   logic wr_mask_mid;
   logic wr_mask_high;
   logic wr_sense;
   logic wr_ext_flags;
   logic wr_grp_flags;
   logic [`EFPI_EXT_N-1:0] ext_clr;
   logic [`EFPI_GROUP_N-1:0] grp_clr;

   // =================================================================
   // Pin synchronisation

   // Both pin sets share one synchroniser; port direction is not seen
   efpi_sync #(
      .W(`EFPI_SYNC_N)
   ) u_sync (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_async({i_ext_pins, i_change_pins}),
      .o_sync(pins_sync)
   );

   // Previous sample for edge and change compare
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         prev_q <= '0;
      end else begin
         prev_q <= pins_sync;
      end
   end

   // Hold off detection until the history holds real pin levels;
   // otherwise a pin that rests high would look like a rising edge
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         arm_cnt_q <= 2'h0;
      end else if (arm_cnt_q != `EFPI_ARM_CYCLES) begin
         arm_cnt_q <= arm_cnt_q + 2'h1;
      end
   end

   assign armed = (arm_cnt_q == `EFPI_ARM_CYCLES);

   // Split the history into pin sets
   assign ext_cur = pins_sync[`EFPI_SYNC_N-1:`EFPI_CHANGE_N];
   assign ext_prev = prev_q[`EFPI_SYNC_N-1:`EFPI_CHANGE_N];
   assign chg_cur = pins_sync[`EFPI_CHANGE_N-1:0];
   assign chg_prev = prev_q[`EFPI_CHANGE_N-1:0];

   // =================================================================
   // Dedicated pin sensing

   // Field 0 is the first pin, field 1 the second
   always_comb begin
      for (int i = 0; i < `EFPI_EXT_N; i++) begin
         ext_level_mode[i] =
            is_level(sense_q[`EFPI_SENSE_W*i +: `EFPI_SENSE_W]);
         ext_level_low[i] = ext_level_mode[i] & ~ext_cur[i];
         ext_hit[i] = armed &
            edge_hit(sense_q[`EFPI_SENSE_W*i +: `EFPI_SENSE_W],
                     ext_cur[i], ext_prev[i]);
      end
   end

   // =================================================================
   // Pin-change groups

   // Group views: low 7..0, mid 14..8, high 23..16
   always_comb begin
      grp_mask[0] = mask_low_q;
      grp_mask[1] = mask_mid_q & `EFPI_MID_MASK;
      grp_mask[2] = mask_high_q;
      grp_cur[0] = chg_cur[7:0];
      grp_cur[1] = chg_cur[15:8];
      grp_cur[2] = chg_cur[23:16];
      grp_prev[0] = chg_prev[7:0];
      grp_prev[1] = chg_prev[15:8];
      grp_prev[2] = chg_prev[23:16];
      for (int g = 0; g < `EFPI_GROUP_N; g++) begin
         grp_hit[g] = armed & grp_en_q[g] &
            group_hit(grp_mask[g], grp_cur[g], grp_prev[g]);
      end
   end

   // =================================================================
   // Register port decode

   // Writes by exact offset; other offsets are ignored
   always_comb begin
      wr_ext_en = 1'b0;
      wr_grp_en = 1'b0;
      wr_mask_low = 1'b0;
      wr_mask_mid = 1'b0;
      wr_mask_high = 1'b0;
      wr_sense = 1'b0;
      wr_ext_flags = 1'b0;
      wr_grp_flags = 1'b0;
      if (!i_bus.wr) begin
         wr_ext_en = 1'b0;
      end else if (i_bus.addr == `EFPI_OFS_EXT_ENABLE) begin
         wr_ext_en = 1'b1;
      end else if (i_bus.addr == `EFPI_OFS_GROUP_ENABLE) begin
         wr_grp_en = 1'b1;
      end else if (i_bus.addr == `EFPI_OFS_MASK_LOW) begin
         wr_mask_low = 1'b1;
      end else if (i_bus.addr == `EFPI_OFS_MASK_MID) begin
         wr_mask_mid = 1'b1;
      end else if (i_bus.addr == `EFPI_OFS_MASK_HIGH) begin
         wr_mask_high = 1'b1;
      end else if (i_bus.addr == `EFPI_OFS_SENSE) begin
         wr_sense = 1'b1;
      end else if (i_bus.addr == `EFPI_OFS_EXT_FLAGS) begin
         wr_ext_flags = 1'b1;
      end else if (i_bus.addr == `EFPI_OFS_GROUP_FLAGS) begin
         wr_grp_flags = 1'b1;
      end
   end

   // Clear sources: a written one or routine entry
   assign ext_clr = (wr_ext_flags ? i_bus.wdata[`EFPI_EXT_N-1:0]
                                  : '0) | i_ack.ext;
   assign grp_clr = (wr_grp_flags ? i_bus.wdata[`EFPI_GROUP_N-1:0]
                                  : '0) | i_ack.group;

   // =================================================================
   // Control registers; unused bits are never stored

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         ext_en_q <= '0;
         grp_en_q <= '0;
         sense_q <= '0;
      end else begin
         if (wr_ext_en) begin
            ext_en_q <= i_bus.wdata[`EFPI_EXT_N-1:0];
         end
         if (wr_grp_en) begin
            grp_en_q <= i_bus.wdata[`EFPI_GROUP_N-1:0];
         end
         if (wr_sense) begin
            sense_q <= i_bus.wdata[`EFPI_SENSE_BITS-1:0];
         end
      end
   end

   // Mask registers
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         mask_low_q <= `EFPI_RST_BYTE;
         mask_mid_q <= `EFPI_RST_BYTE;
         mask_high_q <= `EFPI_RST_BYTE;
      end else begin
         if (wr_mask_low) begin
            mask_low_q <= i_bus.wdata;
         end
         if (wr_mask_mid) begin
            mask_mid_q <= i_bus.wdata & `EFPI_MID_MASK;
         end
         if (wr_mask_high) begin
            mask_high_q <= i_bus.wdata;
         end
      end
   end

   // =================================================================
   // Flags: a new event wins over a clear in the same cycle

   always_comb begin
      for (int i = 0; i < `EFPI_EXT_N; i++) begin
         if (ext_level_mode[i]) begin
            ext_flag_d[i] = 1'b0;
         end else begin
            ext_flag_d[i] = (ext_flag_q[i] & ~ext_clr[i]) |
                            ext_hit[i];
         end
      end
      grp_flag_d = (grp_flag_q & ~grp_clr) | grp_hit;
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         ext_flag_q <= '0;
         grp_flag_q <= '0;
      end else begin
         ext_flag_q <= ext_flag_d;
         grp_flag_q <= grp_flag_d;
      end
   end

   // =================================================================
   // Requests to the core

   // Level mode requests straight from the synchronised low level, so it drops
   // two clocks after the driver lets go of the pin
   always_comb begin
      for (int i = 0; i < `EFPI_EXT_N; i++) begin
         o_irq_req.ext[i] = i_global_en & ext_en_q[i] &
            (ext_level_mode[i] ? ext_level_low[i]
                               : ext_flag_q[i]);
      end
      o_irq_req.group = {`EFPI_GROUP_N{i_global_en}} & grp_en_q &
                        grp_flag_q;
   end

   assign o_flags.ext = ext_flag_q;
   assign o_flags.group = grp_flag_q;

   // Wake hint for the sleep controller; needs no edge mode.
   // Limitation: the synchroniser still needs the clock to run.
   assign o_wake = |(ext_level_low & ext_en_q) |
                   |(grp_flag_q & grp_en_q);

   // =================================================================
   // Read port: data stand for the one cycle after the strobe

   always_comb begin
      rdata_d = `EFPI_RST_BYTE;
      if (!i_bus.rd) begin
         rdata_d = `EFPI_RST_BYTE;
      end else if (i_bus.addr == `EFPI_OFS_EXT_ENABLE) begin
         rdata_d[`EFPI_EXT_N-1:0] = ext_en_q;
      end else if (i_bus.addr == `EFPI_OFS_GROUP_ENABLE) begin
         rdata_d[`EFPI_GROUP_N-1:0] = grp_en_q;
      end else if (i_bus.addr == `EFPI_OFS_MASK_LOW) begin
         rdata_d = mask_low_q;
      end else if (i_bus.addr == `EFPI_OFS_MASK_MID) begin
         rdata_d = mask_mid_q & `EFPI_MID_MASK;
      end else if (i_bus.addr == `EFPI_OFS_MASK_HIGH) begin
         rdata_d = mask_high_q;
      end else if (i_bus.addr == `EFPI_OFS_SENSE) begin
         rdata_d[`EFPI_SENSE_BITS-1:0] = sense_q;
      end else if (i_bus.addr == `EFPI_OFS_EXT_FLAGS) begin
         rdata_d[`EFPI_EXT_N-1:0] = ext_flag_q;
      end else if (i_bus.addr == `EFPI_OFS_GROUP_FLAGS) begin
         rdata_d[`EFPI_GROUP_N-1:0] = grp_flag_q;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         rdata_q <= `EFPI_RST_BYTE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign o_rdata = rdata_q;

endmodule

/* tb/efpi_sva.sv */
/*
 * Assertion checker for efpi_top, bound to it at the foot.
 * Assumes only the top ports; shadows the control bits from writes.
 */
`timescale 1ns/100ps

module efpi_sva
   import efpi_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input efpi_bus_s i_bus,
   input wire logic [7:0] o_rdata,
   input wire logic i_global_en,
   input efpi_irq_s i_ack,
   input wire logic [1:0] i_ext_pins,
   input wire logic [23:0] i_change_pins,
   input efpi_irq_s o_irq_req,
   input efpi_irq_s o_flags,
   input wire logic o_wake
);
   logic [3:0] sense_q;
   logic [1:0] en_q;
   logic [2:0] gen_q;
   logic [25:0] pin_q;
   logic [2:0] quiet_q;

   // Shadow of sense and enable bits, as the core wrote them
   always_ff @(posedge i_mclk) begin
      if (i_rst) begin
         sense_q <= 4'h0;
         en_q <= 2'h0;
         gen_q <= 3'h0;
      end else if (i_bus.wr) begin
         if (i_bus.addr == 8'h69) sense_q <= i_bus.wdata[3:0];
         if (i_bus.addr == 8'h3d) en_q <= i_bus.wdata[1:0];
         if (i_bus.addr == 8'h68) gen_q <= i_bus.wdata[2:0];
      end
   end

   // Cycles since any pin moved; a clear only counts when no event races it
   always_ff @(posedge i_mclk) begin
      pin_q <= {i_ext_pins, i_change_pins};
      if (i_rst || pin_q != {i_ext_pins, i_change_pins})
         quiet_q <= 3'h0;
      else if (quiet_q != 3'h7)
         quiet_q <= quiet_q + 3'h1;
   end

   // ====================================================
   // Properties
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);

   property p_unused;
      $past(i_bus.rd) && $past(i_bus.addr) == 8'h3d |-> o_rdata[7:2] == 6'h0;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused enable bits read nonzero");
   property p_mid7;
      $past(i_bus.rd) && $past(i_bus.addr) == 8'h6c |-> !o_rdata[7];
   endproperty
   a_mid7: assert property (p_mid7)
      else $error("middle mask top bit read nonzero");
   property p_ext_gate;
      (o_irq_req.ext & ~(en_q & {2{i_global_en}})) == 2'h0;
   endproperty
   a_ext_gate: assert property (p_ext_gate)
      else $error("pin request without both enables");
   property p_grp_gate;
      (o_irq_req.group & ~(o_flags.group & gen_q & {3{i_global_en}}))
         == 3'h0;
   endproperty
   a_grp_gate: assert property (p_grp_gate)
      else $error("group request without flag and enables");
   property p_edge_req;
      sense_q[1] |-> o_irq_req.ext[0] ==
         (o_flags.ext[0] && en_q[0] && i_global_en);
   endproperty
   a_edge_req: assert property (p_edge_req)
      else $error("edge request does not follow flag");
   property p_lvl_flag;
      sense_q[1:0] == 2'h0 && $past(sense_q[1:0]) == 2'h0 |-> !o_flags.ext[0];
   endproperty
   a_lvl_flag: assert property (p_lvl_flag)
      else $error("flag set in level mode");
   property p_ack_clr;
      i_ack.ext[1] && quiet_q > 3'h4 |=> !o_flags.ext[1];
   endproperty
   a_ack_clr: assert property (p_ack_clr)
      else $error("routine entry left pin flag set");
   property p_w1c;
      i_bus.wr && i_bus.addr == 8'h3b && i_bus.wdata[2] && quiet_q > 3'h4
         |=> !o_flags.group[2];
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("written one left group flag set");
   property p_level;
      (sense_q[1:0] == 2'h0 && en_q[0] && i_global_en && !i_ext_pins[0])[*4]
         |-> o_irq_req.ext[0];
   endproperty
   a_level: assert property (p_level)
      else $error("held low level not requesting");
endmodule

bind efpi_top efpi_sva efpi_sva_inst (
   .i_mclk(i_mclk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
   .i_global_en(i_global_en), .i_ack(i_ack), .i_ext_pins(i_ext_pins),
   .i_change_pins(i_change_pins), .o_irq_req(o_irq_req),
   .o_flags(o_flags), .o_wake(o_wake));

/* tb/efpi_pins_model.sv */
/*
 * Board side: drives the two dedicated pins and 24 change pins.
 * Assumes the bench names the wanted levels; lines idle high.
 */
`timescale 1ns/100ps

module efpi_pins_model (
   input wire logic i_mclk,
   input wire logic i_slow,
   input wire logic [25:0] i_want,
   output logic [25:0] o_pins
);
   logic [2:0] hold_q;

   // Pulled-up lines until the board drives them
   initial begin
      o_pins = '1;
      hold_q = 3'h0;
   end

   // Each level stands three clocks or more, so no pulse is lost
   always @(posedge i_mclk) begin
      if (hold_q != 3'h0)
         hold_q <= hold_q - 3'h1;
      else if (i_want != o_pins) begin
         o_pins <= i_want;
         hold_q <= i_slow ? 3'h6 : 3'h2;
      end
   end
endmodule

/* tb/testbench.sv */
/*
 * Self-checking bench for efpi_top with a reference model of flags,
 * requests and wake.
 * Assumes a 50 MHz clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps

module testbench
   import efpi_pkg::*;
;
   logic i_mclk, i_rst, i_global_en, o_wake, slow;
   efpi_bus_s bus;
   efpi_irq_s ack, req, flg;
   logic [7:0] rdata;
   logic [25:0] want, pins;
   int bad_count, compares, ef, gf, sense, en, gen;
   int msk[3];
   logic [7:0] ofs[8] = '{8'h69, 8'h3d, 8'h3c, 8'h68, 8'h3b, 8'h6b,
      8'h6c, 8'h6d};
   logic [7:0] rbk[8] = '{8'h0f, 8'h03, 8'h00, 8'h07, 8'h00, 8'hff,
      8'h7f, 8'hff};

   // 20 ns clock
   initial begin
      i_mclk = 1'b0;
      forever #10 i_mclk = ~i_mclk;
   end

   efpi_top efpi_top_inst (
      .i_mclk(i_mclk), .i_rst(i_rst), .i_bus(bus), .o_rdata(rdata),
      .i_global_en(i_global_en), .i_ack(ack), .i_ext_pins(pins[25:24]),
      .i_change_pins(pins[23:0]), .o_irq_req(req), .o_flags(flg),
      .o_wake(o_wake));
   efpi_pins_model efpi_pins_model_inst (.i_mclk(i_mclk),
      .i_slow(slow), .i_want(want), .o_pins(pins));

   // ====================================================
   // Tasks, all entered just after a rising edge
   task automatic chk(string nm, int e, logic [7:0] g);
      compares++;
      if (g !== 8'(e)) begin
         bad_count++;
         $display("wrong value %s: expected %h seen %h", nm, 8'(e), g);
      end
   endtask

   // A gap cycle after each access keeps strobes from double assignment
   task automatic wr(logic [7:0] a, logic [7:0] d);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge i_mclk);
      bus.wr <= 1'b0;
      @(posedge i_mclk);
   endtask

   task automatic rd(logic [7:0] a, int e, string nm);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge i_mclk);
      bus.rd <= 1'b0;
      #1 chk(nm, e, rdata);
      @(posedge i_mclk);
   endtask

   task automatic look();
      int lv = 0;
      int g = i_global_en;
      for (int i = 0; i < 2; i++)
         if (((sense >> (2 * i)) & 3) == 0) begin
            ef &= ~(1 << i);
            if (!want[24 + i] && ((en >> i) & 1)) lv |= 1 << i;
         end
      chk("ext flags", ef, 8'(flg.ext));
      chk("group flags", gf, 8'(flg.group));
      chk("ext req", g ? (ef & en) | lv : 0, 8'(req.ext));
      chk("group req", g ? gf & gen : 0, 8'(req.group));
      // Wake ignores the global enable, so it is checked in every mode
      chk("wake", (gf & gen) != 0 || lv != 0, 8'(o_wake));
   endtask

   // New pin levels; events predicted from old and new levels
   task automatic drive(logic [25:0] v);
      logic [25:0] ch;
      int m;
      ch = v ^ want;
      want <= v;
      for (int i = 0; i < 2; i++) begin
         m = (sense >> (2 * i)) & 3;
         if (ch[24 + i] && (m == 1 || (m == 2 && !v[24 + i]) ||
               (m == 3 && v[24 + i])))
            ef |= 1 << i;
      end
      for (int g = 0; g < 3; g++)
         if ((ch[8 * g +: 8] & msk[g]) != 0 && ((gen >> g) & 1))
            gf |= 1 << g;
      repeat (12) @(posedge i_mclk);
      look();
   endtask

   task automatic clr(logic [7:0] a, logic [7:0] d);
      wr(a, d);
      if (a == 8'h3c) ef &= ~int'(d);
      else gf &= ~int'(d);
      look();
   endtask

   task automatic ackp(efpi_irq_s a);
      ack <= a;
      @(posedge i_mclk);
      ack <= '0;
      ef &= ~int'(a.ext);
      gf &= ~int'(a.group);
      @(posedge i_mclk);
      look();
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Hang guard, well beyond the few hundred cycles of the tests
   initial begin
      #400000;
      bad_count++;
      summarize();
   end

   // ====================================================
   // Main sequence
   initial begin
      bad_count = 0;
      compares = 0;
      i_rst = 1'b1;
      i_global_en = 1'b0;
      slow = 1'b0;
      bus = '0;
      ack = '0;
      want = '1;
      {ef, gf, sense, en, gen} = '0;
      msk = '{0, 0, 0};
      void'($urandom(32'h64fda47a));
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
      foreach (ofs[k]) rd(ofs[k], 0, "reset value");
      foreach (ofs[k]) begin
         wr(ofs[k], 8'hff);
         rd(ofs[k], rbk[k], "readback");
      end
      rd(8'h00, 0, "unmapped");
      {sense, en, gen} = {32'd15, 32'd3, 32'd7};
      msk = '{255, 127, 255};
      // Every sense code on both pins, with enables varied
      for (int m = 0; m < 4; m++) begin
         i_global_en <= (m != 2);
         sense = m * 5;
         en = (m == 1) ? 1 : 3;
         wr(8'h3d, 8'(en));
         wr(8'h69, 8'(sense));
         drive(want & ~26'h1000000);
         drive(want & ~26'h2000000);
         drive(want | 26'h3000000);
         clr(8'h3c, 8'h00);
         clr(8'h3c, 8'h01);
         ackp(efpi_irq_s'(5'h02));
      end
      // Random masks, group enables and change-pin traffic
      for (int t = 0; t < 12; t++) begin
         gen = $urandom_range(7);
         wr(8'h68, 8'(gen));
         for (int g = 0; g < 3; g++) begin
            msk[g] = $urandom_range(255);
            wr(8'h6b + 8'(g), 8'(msk[g]));
         end
         msk[1] &= 127;
         slow <= 1'(t & 1);
         drive({want[25:24], 24'($urandom)});
         if (t % 3 == 0) ackp(efpi_irq_s'(5'h1c));
         else clr(8'h3b, 8'($urandom_range(7)));
      end
      // Mid-run reset with flags pending: all state back to zero
      drive(want ^ 26'h0ffffff);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
      {ef, gf, sense, en, gen} = '0;
      msk = '{0, 0, 0};
      foreach (ofs[k]) rd(ofs[k], 0, "reset again");
      look();
      clr(8'h3b, 8'h07);
      summarize();
   end
endmodule
